// ==== src/cfo_comparator_ctrl.sv ====
// register file, input synchronisers and comparator1 sample filter for two analog comparators
// assumes raw comparator outputs and slow oscillators arrive asynchronously on pins
`timescale 1ns/100ps

// How it works
// [RULE1] filter samples on bus, lsi or lse clock
// [RULE2] filtered output changes after count consistent samples
// [RULE3] period equals count field, no offset
// [RULE4] bit 0 turns digital filter on
// [RULE5] software writes filter enable while comp1 off
// [RULE6] bit 30 reads comparator2 output after polarity
// [RULE7] bit 15 inverts comparator2 output
// [RULE8] bits 19:18 select high or medium speed
// [RULE9] bit 11 routes comp1 positive input to comp2
// [RULE10] software never sets both window bits
// [RULE11] bit 0 enables comparator, readable and writable
// [RULE12] filter disabled passes raw output directly
// [RULE13] reserved bits read zero, writes ignored
module cfo_comparator_ctrl
    import cfo_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comp1RawOut,
    input  wire logic        comp2RawOut,
    input  wire logic        lowSpeedInternalOsc,
    input  wire logic        lowSpeedExternalOsc,
    output logic             comp1Filtered,
    output logic             comp2Status,
    output cfo_analog_s      analogCtrl
);

    typedef struct packed {
        cfo_bus_e    busState;
        logic [11:0] busAddr;
        logic [31:0] readData;
        cfo_sync_s   compSync;
        logic [2:0]  lsiSync;
        logic [2:0]  lseSync;
        logic [1:0]  filterSource;
        logic [15:0] filterSampleCount;
        logic        filterEnableBit;
        logic        polarity;
        cfo_analog_s analog;
        logic [15:0] sampleRun;
        logic        filtered;
        logic        comp2Out;
    } cfo_state_s;

    cfo_state_s state_r;
    cfo_state_s state_nxt;

    logic        addrValid;
    logic        sampleTick;
    logic        rawComp1;
    logic        rawComp2;

    // rising edge seen between the second and third stages, the first stage feeds nothing else
    function automatic logic rise3(input logic [2:0] sh);
        rise3 = sh[1] & ~sh[2];
    endfunction

    // each read word starts from zero, so reserved bits can never leak state
    function automatic logic [31:0] readC1Ctl(input cfo_state_s s);
        logic [31:0] w;
        w                      = WORD_ZERO;
        w[C1_EN_BIT]           = s.analog.comp1Enable;
        w[C1_SRC_HI:C1_SRC_LO] = s.filterSource;
        readC1Ctl = w;
    endfunction

    function automatic logic [31:0] readFilt(input cfo_state_s s);
        logic [31:0] w;
        w                        = WORD_ZERO;
        w[FLT_CNT_HI:FLT_CNT_LO] = s.filterSampleCount;
        w[FLT_EN_BIT]            = s.filterEnableBit;
        readFilt = w;
    endfunction

    // status comes from the registered output, never straight from a pin
    function automatic logic [31:0] readC2Csr(input cfo_state_s s);
        logic [31:0] w;
        w                      = WORD_ZERO;
        w[C2_EN_BIT]           = s.analog.comp2Enable;
        w[C2_HYST_BIT]         = s.analog.comp2Hysteresis;
        w[C2_NEG_HI:C2_NEG_LO] = s.analog.negativeInputSelect;
        w[C2_POS_HI:C2_POS_LO] = s.analog.positiveInputSelect;
        w[C2_WIN_BIT]          = s.analog.windowInputShare;
        w[C2_POL_BIT]          = s.polarity;
        w[C2_PWR_HI:C2_PWR_LO] = s.analog.powerSpeedSelect;
        w[C2_OUT_BIT]          = s.comp2Out; // [RULE6]
        readC2Csr = w;
    endfunction

    function automatic logic [31:0] readMux(input cfo_state_s s, input logic [11:0] a);
        logic [31:0] w;
        case (a)
            OFS_C1CTL: begin
                w = readC1Ctl(s);
            end
            OFS_FILT: begin
                w = readFilt(s);
            end
            OFS_C2CSR: begin
                w = readC2Csr(s);
            end
            default: begin
                w = WORD_ZERO;
            end
        endcase
        readMux = w; // [RULE13]
    endfunction

    // writes copy only the defined fields; everything else in the word is dropped
    function automatic cfo_state_s writeC1Ctl(input cfo_state_s s, input logic [31:0] d);
        cfo_state_s r;
        r                    = s;
        r.analog.comp1Enable = d[C1_EN_BIT]; // [RULE11]
        r.filterSource       = d[C1_SRC_HI:C1_SRC_LO];
        writeC1Ctl = r;
    endfunction

    function automatic cfo_state_s writeFilt(input cfo_state_s s, input logic [31:0] d);
        cfo_state_s r;
        r                   = s;
        r.filterSampleCount = d[FLT_CNT_HI:FLT_CNT_LO];
        // accepted at any time; nothing holds it stable while comp1 is on
        r.filterEnableBit   = d[FLT_EN_BIT]; // [RULE4] [RULE5]
        writeFilt = r;
    endfunction

    function automatic cfo_state_s writeC2Csr(input cfo_state_s s, input logic [31:0] d);
        cfo_state_s r;
        r                            = s;
        r.analog.comp2Enable         = d[C2_EN_BIT]; // [RULE11]
        r.analog.comp2Hysteresis     = d[C2_HYST_BIT];
        r.analog.negativeInputSelect = d[C2_NEG_HI:C2_NEG_LO];
        r.analog.positiveInputSelect = d[C2_POS_HI:C2_POS_LO];
        // no check against comp1's window bit, which lives elsewhere
        r.analog.windowInputShare    = d[C2_WIN_BIT]; // [RULE9] [RULE10]
        r.polarity                   = d[C2_POL_BIT];
        // reserved codes are stored as written and left to the analog side
        r.analog.powerSpeedSelect    = d[C2_PWR_HI:C2_PWR_LO]; // [RULE8]
        writeC2Csr = r;
    endfunction

    // code 3 falls back to the bus clock rather than stalling the filter
    function automatic logic selectTick(input logic [1:0] src, input logic [2:0] low_speed_internal_osc,
                                        input logic [2:0] low_speed_external_osc);
        logic t;
        case (src)
            SRC_LSI: begin
                t = rise3(low_speed_internal_osc);
            end
            SRC_LSE: begin
                t = rise3(low_speed_external_osc);
            end
            default: begin
                t = 1'b1;
            end
        endcase
        selectTick = t;
    endfunction

    // a count of zero behaves as one: the change lands on the first sample
    function automatic logic runDone(input logic [15:0] run, input logic [15:0] cnt);
        runDone = ((run + 16'h0001) >= cnt);
    endfunction

    // the filter only runs while both the filter and comparator1 are on
    function automatic logic filterActive(input cfo_state_s s);
        filterActive = s.filterEnableBit & s.analog.comp1Enable;
    endfunction

    // held low while switched off, so software never reads a stale level
    function automatic logic c2Level(input logic en, input logic raw, input logic pol);
        c2Level = en & (raw ^ pol); // [RULE7]
    endfunction

    assign addrValid = hsel & hready & htrans[1];
    assign rawComp1  = state_r.compSync.s2[0];
    assign rawComp2  = state_r.compSync.s2[1];

    // slow sources tick a few cycles after their pin edge: synchroniser plus edge stage
    assign sampleTick = selectTick(state_r.filterSource, state_r.lsiSync, // [RULE1]
                                   state_r.lseSync);

    always_comb begin
        state_nxt = state_r;

        // synchronisers: two flops each before any logic reads the pin
        state_nxt.compSync.s1 = {comp2RawOut, comp1RawOut};
        state_nxt.compSync.s2 = state_r.compSync.s1;
        state_nxt.lsiSync     = {state_r.lsiSync[1:0], lowSpeedInternalOsc};
        state_nxt.lseSync     = {state_r.lseSync[1:0], lowSpeedExternalOsc};

        // bus: writes take effect at the end of their data phase; reads add one
        // wait state so a read right after a write sees the new value
        case (state_r.busState)
            BUS_WRITE: begin
                case (state_r.busAddr)
                    OFS_C1CTL: begin
                        state_nxt = writeC1Ctl(state_nxt, hwdata);
                    end
                    OFS_FILT: begin
                        state_nxt = writeFilt(state_nxt, hwdata);
                    end
                    OFS_C2CSR: begin
                        state_nxt = writeC2Csr(state_nxt, hwdata);
                    end
                    default: begin
                        // unmapped offsets: the write is dropped
                        state_nxt.busState = state_r.busState; // [RULE13]
                    end
                endcase
            end
            BUS_RWAIT: begin
                state_nxt.readData = readMux(state_r, state_r.busAddr);
            end
            default: begin
                state_nxt.readData = state_r.readData;
            end
        endcase

        if (state_r.busState == BUS_RWAIT) begin
            state_nxt.busState = BUS_RDONE;
        end else if (addrValid) begin
            state_nxt.busAddr  = {haddr[11:2], 2'b00};
            state_nxt.busState = hwrite ? BUS_WRITE : BUS_RWAIT;
        end else begin
            state_nxt.busState = BUS_IDLE;
        end

        // comparator1 sample filter
        // raw level, gated by comparator1's enable, passes through when the filter is idle
        if (!filterActive(state_r)) begin
            state_nxt.filtered  = rawComp1 & state_r.analog.comp1Enable; // [RULE12]
            state_nxt.sampleRun = FLT_CNT_RST;
        end else if (sampleTick) begin
            if (rawComp1 == state_r.filtered) begin
                state_nxt.sampleRun = FLT_CNT_RST;
            end else if (runDone(state_r.sampleRun, state_r.filterSampleCount)) begin
                // the run restarts on any agreeing sample, so glitches never add up
                state_nxt.filtered  = rawComp1; // [RULE2] [RULE3]
                state_nxt.sampleRun = FLT_CNT_RST;
            end else begin
                state_nxt.sampleRun = state_r.sampleRun + 16'h0001; // [RULE2]
            end
        end

        // comparator2 status after polarity, registered to match the read path
        state_nxt.comp2Out = c2Level(state_r.analog.comp2Enable, rawComp2, state_r.polarity);
    end

    // reset loads constants only; synchronisers restart low, matching idle pins

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r.busState            <= BUS_IDLE;
            state_r.busAddr             <= 12'h000;
            state_r.readData            <= WORD_ZERO;
            state_r.compSync.s1         <= 2'h0;
            state_r.compSync.s2         <= 2'h0;
            state_r.lsiSync             <= 3'h0;
            state_r.lseSync             <= 3'h0;
            state_r.filterSource        <= SRC_BUS;
            state_r.filterSampleCount   <= FLT_CNT_RST;
            state_r.filterEnableBit     <= 1'b0;
            state_r.polarity            <= 1'b0;
            state_r.analog.comp1Enable         <= 1'b0;
            state_r.analog.comp2Enable         <= 1'b0;
            state_r.analog.comp2Hysteresis     <= 1'b0;
            state_r.analog.powerSpeedSelect    <= PWR_HIGH;
            state_r.analog.positiveInputSelect <= 4'h0;
            state_r.analog.negativeInputSelect <= 4'h0;
            state_r.analog.windowInputShare    <= 1'b0;
            state_r.sampleRun           <= FLT_CNT_RST;
            state_r.filtered            <= 1'b0;
            state_r.comp2Out            <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign hrdata        = state_r.readData;
    assign hreadyout     = (state_r.busState != BUS_RWAIT);
    assign hresp         = 1'b0;
    assign comp1Filtered = state_r.filtered;
    assign comp2Status   = state_r.comp2Out;
    assign analogCtrl    = state_r.analog;

endmodule

// ==== src/cfo_pkg.sv ====
// constants and carrier types for the comparator filter and output control block
// assumes a single 25 MHz system clock and an AHB-Lite master on the register side
package cfo_pkg;
    localparam logic [11:0] OFS_C1CTL = 12'h000;
    localparam logic [11:0] OFS_FILT  = 12'h004;
    localparam logic [11:0] OFS_C2CSR = 12'h010;

    // comparator1 control (enable and filter clock source)
    localparam int C1_EN_BIT   = 0;
    localparam int C1_SRC_LO   = 2;
    localparam int C1_SRC_HI   = 3;
    // filter config
    localparam int FLT_EN_BIT  = 0;
    localparam int FLT_CNT_LO  = 16;
    localparam int FLT_CNT_HI  = 31;
    // comparator2 control and status
    localparam int C2_EN_BIT   = 0;
    localparam int C2_HYST_BIT = 1;
    localparam int C2_NEG_LO   = 2;
    localparam int C2_NEG_HI   = 5;
    localparam int C2_POS_LO   = 6;
    localparam int C2_POS_HI   = 9;
    localparam int C2_WIN_BIT  = 11;
    localparam int C2_POL_BIT  = 15;
    localparam int C2_PWR_LO   = 18;
    localparam int C2_PWR_HI   = 19;
    localparam int C2_OUT_BIT  = 30;

    localparam logic [1:0]  SRC_BUS = 2'h0;
    localparam logic [1:0]  SRC_LSI = 2'h1;
    localparam logic [1:0]  SRC_LSE = 2'h2;
    localparam logic [1:0]  PWR_HIGH = 2'h0;
    localparam logic [1:0]  PWR_MED  = 2'h1;
    localparam logic [15:0] FLT_CNT_RST = 16'h0000;
    localparam logic [31:0] WORD_ZERO   = 32'h00000000;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RWAIT, BUS_RDONE} cfo_bus_e;

    typedef struct packed {
        logic       comp1Enable;
        logic       comp2Enable;
        logic       comp2Hysteresis;
        logic [1:0] powerSpeedSelect;
        logic [3:0] positiveInputSelect;
        logic [3:0] negativeInputSelect;
        logic       windowInputShare;
    } cfo_analog_s;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } cfo_sync_s;
endpackage

// ==== test/cfo_chk.sv ====
// port-level assertions for the comparator control block
// assumes one clock domain and hready tied to hreadyout
`timescale 1ns/100ps
module cfo_chk
    import cfo_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        comp1RawOut,
    input wire logic        comp1Filtered,
    input wire logic        comp2Status,
    input cfo_analog_s      analogCtrl
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic take = hsel && hready && htrans[1];
    wire logic wrC2 = take && hwrite && haddr[11:0] == OFS_C2CSR;
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_write_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_c2_enable: assert property (wrC2 |-> ##2
        analogCtrl.comp2Enable == $past(hwdata[C2_EN_BIT])) else $error("enable not stored");
    a_power_code: assert property (wrC2 |-> ##2
        analogCtrl.powerSpeedSelect == $past(hwdata[19:18])) else $error("power code lost");
    a_window_share: assert property (wrC2 |-> ##2
        analogCtrl.windowInputShare == $past(hwdata[C2_WIN_BIT])) else $error("window lost");
    a_unmapped_zero: assert property (take && !hwrite && haddr[11:0] == 12'h020
        |-> ##2 hrdata == WORD_ZERO) else $error("unmapped read not zero");
    a_filt_source: assert property ($changed(comp1Filtered) && analogCtrl.comp1Enable
        && $past(analogCtrl.comp1Enable) |-> comp1Filtered == $past(comp1RawOut, 3))
        else $error("filtered output not from input");
    a_c2_off_low: assert property (!analogCtrl.comp2Enable [*3] |-> !comp2Status)
        else $error("status high while off");
endmodule

bind cfo_comparator_ctrl cfo_chk chk_u (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .comp1RawOut, .comp1Filtered,
    .comp2Status, .analogCtrl);

// ==== test/cfo_test.sv ====
// self-checking bench for the comparator control block
// drives the ahb-lite port and the raw comparator and oscillator pins
`timescale 1ns/100ps
module comparator_filter_and_output_control_test
    import cfo_pkg::*;
;
    logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic        comp1RawOut = 1'b0, comp2RawOut = 1'b0, low_speed_internal_osc = 1'b0, low_speed_external_osc = 1'b0;
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, comp1Filtered, comp2Status;
    cfo_analog_s      analogCtrl;
    wire logic        hready = hreadyout;
    int               n_mismatch = 0, total_checks = 0;
    cfo_comparator_ctrl dut_u (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .comp1RawOut,
        .comp2RawOut, .lowSpeedInternalOsc(low_speed_internal_osc), .lowSpeedExternalOsc(low_speed_external_osc),
        .comp1Filtered, .comp2Status, .analogCtrl);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // master holds each phase until hready is seen high at an edge
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task t_reset;
        rdc(32'h4, 32'h0);
        rdc(32'h10, 32'h0);
        chk("ctrl", 32'h0, 32'(analogCtrl));
    endtask
    task t_regs;
        bus(1'b1, 32'h4, 32'hffffffff);
        rdc(32'h4, 32'hffff0001);
        bus(1'b1, 32'h4, 32'h0);
        bus(1'b1, 32'h10, 32'hffffffff);
        tick(4);
        rdc(32'h10, 32'h400c8bff);
        chk("ctrl", 32'h1fff, 32'(analogCtrl));
        bus(1'b1, 32'h20, 32'hffffffff);
        rdc(32'h20, 32'h0);
    endtask
    task t_pol;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 32'h10, {16'h0, i[1], 14'h0, 1'b1});
            comp2RawOut <= i[0];
            tick(4);
            chk("status", 32'(i[1] ^ i[0]), 32'(comp2Status));
            rdc(32'h10, {1'b0, i[1] ^ i[0], 14'h0, i[1], 14'h0, 1'b1});
        end
    endtask
    task t_pwr;
        for (int i = 0; i < 4; i++) begin
            // comp1's window bit is never set here, so only one side shares
            bus(1'b1, 32'h10, {12'h0, i[1:0], 6'h0, i[0], 11'h0});
            tick(1);
            chk("power", 32'(i[1:0]), 32'(analogCtrl.powerSpeedSelect));
            chk("window", 32'(i[0]), 32'(analogCtrl.windowInputShare));
        end
    endtask
    // filter is only reprogrammed with comp1 off
    task t_filt;
        bus(1'b1, 32'h4, 32'h00080000);
        bus(1'b1, 32'h0, 32'h1);
        comp1RawOut <= 1'b1;
        tick(4);
        chk("unfiltered", 32'h1, 32'(comp1Filtered));
        bus(1'b1, 32'h0, 32'h0);
        bus(1'b1, 32'h4, 32'h00080001);
        bus(1'b1, 32'h0, 32'h1);
        tick(14);
        comp1RawOut <= 1'b0;
        tick(6);
        comp1RawOut <= 1'b1;
        tick(12);
        chk("short pulse", 32'h1, 32'(comp1Filtered));
        comp1RawOut <= 1'b0;
        tick(9);
        chk("early", 32'h1, 32'(comp1Filtered));
        tick(3);
        chk("settled", 32'h0, 32'(comp1Filtered));
    endtask
    // slow sources: no oscillator edge means no sample
    task t_osc;
        comp1RawOut <= 1'b1;
        for (int s = 1; s < 3; s++) begin
            bus(1'b1, 32'h0, 32'h0);
            bus(1'b1, 32'h4, 32'h00020001);
            bus(1'b1, 32'h0, 32'(1 | (s << 2)));
            tick(20);
            chk("no ticks", 32'h0, 32'(comp1Filtered));
            repeat (6) begin
                tick(3);
                if (s == 1) low_speed_internal_osc <= ~low_speed_internal_osc;
                else low_speed_external_osc <= ~low_speed_external_osc;
            end
            tick(6);
            chk("osc ticks", 32'h1, 32'(comp1Filtered));
        end
    endtask
    initial begin
        tick(8);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_pol;
        t_pwr;
        t_filt;
        t_osc;
        give_verdict;
    end
    initial begin
        #800000;
        n_mismatch++;
        give_verdict;
    end
endmodule
